// ---- rtl/level_detect_pkg.sv ----
// Constants for the drive output level detectors: register map, resets, limits, timing.
// Assumes a 200 MHz system clock and a 16-bit register port.
package level_detect_pkg;

  // Register offsets
  localparam logic [15:0] OFF_DO_SELECT       = 16'h0A01;
  localparam logic [15:0] OFF_RELAY_SELECT    = 16'h0A02;
  localparam logic [15:0] OFF_FREQ_CENTRE     = 16'h0A19;
  localparam logic [15:0] OFF_FREQ_AMPLITUDE  = 16'h0A1A;
  localparam logic [15:0] OFF_ZERO_LEVEL      = 16'h0A1D;
  localparam logic [15:0] OFF_ZERO_DELAY      = 16'h0A1E;
  localparam logic [15:0] OFF_OVER_THRESHOLD  = 16'h0A1F;
  localparam logic [15:0] OFF_OVER_DELAY      = 16'h0A20;
  localparam logic [15:0] OFF_IRQ_STATUS      = 16'h0B00;
  localparam logic [15:0] OFF_IRQ_MASK        = 16'h0B01;
  localparam logic [15:0] OFF_FLAG_STATE      = 16'h0B02;

  // Reset values (frequency 0.01 Hz, percent 0.1 %, delay 0.01 s)
  localparam logic [15:0] RST_DO_SELECT       = 16'h0002;
  localparam logic [15:0] RST_RELAY_SELECT    = 16'h0008;
  localparam logic [15:0] RST_FREQ_CENTRE     = 16'h1388;
  localparam logic [15:0] RST_FREQ_AMPLITUDE  = 16'h0000;
  localparam logic [15:0] RST_ZERO_LEVEL      = 16'h0032;
  localparam logic [15:0] RST_ZERO_DELAY      = 16'h000A;
  localparam logic [15:0] RST_OVER_THRESHOLD  = 16'h07D0;
  localparam logic [15:0] RST_OVER_DELAY      = 16'h0001;
  localparam logic [2:0]  RST_IRQ_MASK        = 3'h0;

  // Accepted ranges
  localparam logic [15:0] MAX_SELECT          = 16'h0023;
  localparam logic [15:0] MAX_PERCENT_100     = 16'h03E8;
  localparam logic [15:0] MAX_PERCENT_300     = 16'h0BB8;
  localparam logic [15:0] MIN_ZERO_DELAY      = 16'h0001;
  localparam logic [15:0] MAX_DELAY           = 16'hEA60;
  localparam logic [31:0] PERCENT_SCALE       = 32'h0000_03E8;

  // Function selector codes
  localparam logic [15:0] SEL_ZERO_CURRENT    = 16'h0007;
  localparam logic [15:0] SEL_ANY_FREQUENCY   = 16'h0016;
  localparam logic [15:0] SEL_OVERCURRENT     = 16'h001E;

  // Flag bit positions in status, mask and state registers
  localparam int FLAG_ANY_FREQUENCY = 0;
  localparam int FLAG_ZERO_CURRENT  = 1;
  localparam int FLAG_OVERCURRENT   = 2;
  localparam int FLAG_COUNT         = 3;

  // Timing: one delay unit is 10 ms
  localparam int CLOCK_MHZ     = 200;
  localparam int DELAY_UNIT_US = 10000;
  localparam int TICK_CYCLES   = DELAY_UNIT_US * CLOCK_MHZ;

endpackage

// ---- rtl/persist_timer.sv ----
// Persistence timer: flag rises once a condition has held longer than a delay.
// Assumes cond and delay come from logic on the same clock.
`timescale 1ns/100ps
module persist_timer #(
  parameter int TICK_CYCLES = level_detect_pkg::TICK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        cond,
  input  wire logic [15:0] delay,
  output logic             flag
);

  localparam int SW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [SW-1:0] SUB_LAST = SW'(TICK_CYCLES - 1);

  if (TICK_CYCLES < 1) begin : g_check
    $error("persist_timer: TICK_CYCLES must be at least 1");
  end

  logic [SW-1:0] sub;
  logic [16:0]   ticks;
  logic [SW-1:0] next_sub;
  logic [16:0]   next_ticks;
  logic          next_flag;

  always_comb begin
    next_sub   = '0;
    next_ticks = '0;
    next_flag  = 1'b0;
    if (cond) begin
      next_ticks = ticks;
      if (sub == SUB_LAST) begin
        next_sub = '0;
        if (ticks != 17'h1FFFF) begin
          next_ticks = ticks + 17'h00001;
        end
      end else begin
        next_sub = sub + SW'(1);
      end
      next_flag = next_ticks > {1'b0, delay}; // [RULE_07] [RULE_10]
    end
  end // [RULE_12]

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sub   <= '0;
      ticks <= '0;
      flag  <= 1'b0;
    end else begin
      sub   <= next_sub;
      ticks <= next_ticks;
      flag  <= next_flag;
    end
  end

  property p_drop_on_release;
    @(posedge clock) disable iff (rst) !cond |=> !flag;
  endproperty
  a_drop_on_release: assert property (p_drop_on_release) // [RULE_12]
    else $error("flag stayed high after condition ended");

  property p_rise_needs_time;
    @(posedge clock) disable iff (rst) $rose(flag) |-> ticks > {1'b0, delay} && $past(cond);
  endproperty
  a_rise_needs_time: assert property (p_rise_needs_time) // [RULE_07]
    else $error("flag rose before delay elapsed");

endmodule

// ---- rtl/drive_output_level_detectors.sv ----
// Frequency-window and current-level detectors with routing to output and relay.
// Assumes measured values and the maximum-frequency setting come from logic on clock.
//
// Notes on behaviour
// [RULE_01] Any-frequency flag is high while frequency lies in centre plus or minus amplitude.
// [RULE_02] Amplitude equals maximum frequency times amplitude percentage.
// [RULE_03] Centre accepted from zero to maximum frequency, resets to 50.00 Hz.
// [RULE_04] Amplitude percentage accepted from 0.0 to 100.0 percent, resets to zero.
// [RULE_05] Selector code 22 routes the any-frequency flag.
// [RULE_06] Current is low at or below zero level; default 5.0, range 0.0-300.0 percent.
// [RULE_07] Zero flag rises after low current outlasts delay; default 0.10 s, 0.01-600 s.
// [RULE_08] Selector code 7 routes the zero-current flag.
// [RULE_09] Current is over limit above threshold, default 200.0 percent.
// [RULE_10] Over flag rises after over-limit outlasts delay; default 0.01 s, 0-600 s.
// [RULE_11] Selector code 30 routes the overcurrent flag.
// [RULE_12] Delayed flags drop and timers restart when their condition ends.
// [RULE_13] Output terminal and relay each follow their own selector independently.
`timescale 1ns/100ps
module drive_output_level_detectors #(
  parameter int TICK_CYCLES = level_detect_pkg::TICK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [15:0] rd_data,
  input  wire logic [15:0] operating_frequency,
  input  wire logic [15:0] output_current,
  input  wire logic [15:0] maximum_frequency_setting,
  output logic             do_out,
  output logic             relay_out,
  output logic             irq
);

  localparam int NF = level_detect_pkg::FLAG_COUNT;

  if (TICK_CYCLES < 1) begin : g_check
    $error("drive_output_level_detectors: TICK_CYCLES must be at least 1");
  end

  // Configuration registers
  logic [15:0]   do_select;
  logic [15:0]   relay_select;
  logic [15:0]   freq_centre;
  logic [15:0]   freq_amplitude;
  logic [15:0]   zero_level;
  logic [15:0]   zero_delay;
  logic [15:0]   over_threshold;
  logic [15:0]   over_delay;
  logic [NF-1:0] irq_status;
  logic [NF-1:0] irq_mask;
  logic [15:0]   next_do_select;
  logic [15:0]   next_relay_select;
  logic [15:0]   next_freq_centre;
  logic [15:0]   next_freq_amplitude;
  logic [15:0]   next_zero_level;
  logic [15:0]   next_zero_delay;
  logic [15:0]   next_over_threshold;
  logic [15:0]   next_over_delay;
  logic [NF-1:0] next_irq_status;
  logic [NF-1:0] next_irq_mask;
  logic [15:0]   next_rd_data;

  // Detector state
  logic [15:0]   amplitude;
  logic          in_window;
  logic          low_current;
  logic          high_current;
  logic          zero_flag;
  logic          over_flag;
  logic [NF-1:0] flags;
  logic [NF-1:0] flags_prev;
  logic [15:0]   next_amplitude;
  logic          next_in_window;
  logic          next_low_current;
  logic          next_high_current;
  logic [31:0]   amp_product;
  logic [16:0]   win_high;
  logic [16:0]   win_low;

  // Output state
  logic          next_do_out;
  logic          next_relay_out;

  function automatic logic route(input logic [15:0] sel, input logic [NF-1:0] f);
    logic r;
    r = 1'b0;
    case (sel)
      level_detect_pkg::SEL_ANY_FREQUENCY: r = f[level_detect_pkg::FLAG_ANY_FREQUENCY];
      level_detect_pkg::SEL_ZERO_CURRENT:  r = f[level_detect_pkg::FLAG_ZERO_CURRENT];
      level_detect_pkg::SEL_OVERCURRENT:   r = f[level_detect_pkg::FLAG_OVERCURRENT];
      default:                             r = 1'b0;
    endcase
    return r;
  endfunction // [RULE_05] [RULE_08] [RULE_11]

  // Register writes, interrupt status and read data
  always_comb begin
    next_do_select      = do_select;
    next_relay_select   = relay_select;
    next_freq_centre    = freq_centre;
    next_freq_amplitude = freq_amplitude;
    next_zero_level     = zero_level;
    next_zero_delay     = zero_delay;
    next_over_threshold = over_threshold;
    next_over_delay     = over_delay;
    next_irq_mask       = irq_mask;
    next_irq_status     = irq_status;
    next_rd_data        = 16'h0000;
    if (wr_en) begin
      unique case (addr)
        level_detect_pkg::OFF_DO_SELECT: begin
          if (wr_data <= level_detect_pkg::MAX_SELECT) begin
            next_do_select = wr_data;
          end
        end
        level_detect_pkg::OFF_RELAY_SELECT: begin
          if (wr_data <= level_detect_pkg::MAX_SELECT) begin
            next_relay_select = wr_data;
          end
        end
        level_detect_pkg::OFF_FREQ_CENTRE: begin
          if (wr_data <= maximum_frequency_setting) begin
            next_freq_centre = wr_data; // [RULE_03]
          end
        end
        level_detect_pkg::OFF_FREQ_AMPLITUDE: begin
          if (wr_data <= level_detect_pkg::MAX_PERCENT_100) begin
            next_freq_amplitude = wr_data; // [RULE_04]
          end
        end
        level_detect_pkg::OFF_ZERO_LEVEL: begin
          if (wr_data <= level_detect_pkg::MAX_PERCENT_300) begin
            next_zero_level = wr_data; // [RULE_06]
          end
        end
        level_detect_pkg::OFF_ZERO_DELAY: begin
          if (wr_data >= level_detect_pkg::MIN_ZERO_DELAY &&
              wr_data <= level_detect_pkg::MAX_DELAY) begin
            next_zero_delay = wr_data; // [RULE_07]
          end
        end
        level_detect_pkg::OFF_OVER_THRESHOLD: begin
          if (wr_data <= level_detect_pkg::MAX_PERCENT_300) begin
            next_over_threshold = wr_data; // [RULE_09]
          end
        end
        level_detect_pkg::OFF_OVER_DELAY: begin
          if (wr_data <= level_detect_pkg::MAX_DELAY) begin
            next_over_delay = wr_data; // [RULE_10]
          end
        end
        level_detect_pkg::OFF_IRQ_STATUS: begin
          next_irq_status = irq_status & ~wr_data[NF-1:0];
        end
        level_detect_pkg::OFF_IRQ_MASK: begin
          next_irq_mask = wr_data[NF-1:0];
        end
        default: begin
        end
      endcase
    end
    // Rising flags set status; set wins over a same-cycle clear
    next_irq_status = next_irq_status | (flags & ~flags_prev);
    if (rd_en) begin
      unique case (addr)
        level_detect_pkg::OFF_DO_SELECT:      next_rd_data = do_select;
        level_detect_pkg::OFF_RELAY_SELECT:   next_rd_data = relay_select;
        level_detect_pkg::OFF_FREQ_CENTRE:    next_rd_data = freq_centre;
        level_detect_pkg::OFF_FREQ_AMPLITUDE: next_rd_data = freq_amplitude;
        level_detect_pkg::OFF_ZERO_LEVEL:     next_rd_data = zero_level;
        level_detect_pkg::OFF_ZERO_DELAY:     next_rd_data = zero_delay;
        level_detect_pkg::OFF_OVER_THRESHOLD: next_rd_data = over_threshold;
        level_detect_pkg::OFF_OVER_DELAY:     next_rd_data = over_delay;
        level_detect_pkg::OFF_IRQ_STATUS:     next_rd_data = {{(16-NF){1'b0}}, irq_status};
        level_detect_pkg::OFF_IRQ_MASK:       next_rd_data = {{(16-NF){1'b0}}, irq_mask};
        level_detect_pkg::OFF_FLAG_STATE:     next_rd_data = {{(16-NF){1'b0}}, flags};
        default:                              next_rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      do_select      <= level_detect_pkg::RST_DO_SELECT;
      relay_select   <= level_detect_pkg::RST_RELAY_SELECT;
      freq_centre    <= level_detect_pkg::RST_FREQ_CENTRE;
      freq_amplitude <= level_detect_pkg::RST_FREQ_AMPLITUDE;
      zero_level     <= level_detect_pkg::RST_ZERO_LEVEL;
      zero_delay     <= level_detect_pkg::RST_ZERO_DELAY;
      over_threshold <= level_detect_pkg::RST_OVER_THRESHOLD;
      over_delay     <= level_detect_pkg::RST_OVER_DELAY;
      irq_status     <= '0;
      irq_mask       <= level_detect_pkg::RST_IRQ_MASK;
      rd_data        <= 16'h0000;
    end else begin
      do_select      <= next_do_select;
      relay_select   <= next_relay_select;
      freq_centre    <= next_freq_centre;
      freq_amplitude <= next_freq_amplitude;
      zero_level     <= next_zero_level;
      zero_delay     <= next_zero_delay;
      over_threshold <= next_over_threshold;
      over_delay     <= next_over_delay;
      irq_status     <= next_irq_status;
      irq_mask       <= next_irq_mask;
      rd_data        <= next_rd_data;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Comparators
  always_comb begin
    amp_product       = 32'({16'h0000, maximum_frequency_setting} * {16'h0000, freq_amplitude});
    next_amplitude    = 16'(amp_product / level_detect_pkg::PERCENT_SCALE); // [RULE_02]
    win_high          = {1'b0, freq_centre} + {1'b0, amplitude};
    win_low           = (amplitude > freq_centre) ? 17'h00000
                        : ({1'b0, freq_centre} - {1'b0, amplitude});
    next_in_window    = ({1'b0, operating_frequency} >= win_low) &&
                        ({1'b0, operating_frequency} <= win_high); // [RULE_01]
    next_low_current  = output_current <= zero_level; // [RULE_06]
    next_high_current = output_current > over_threshold; // [RULE_09]
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      amplitude    <= 16'h0000;
      in_window    <= 1'b0;
      low_current  <= 1'b0;
      high_current <= 1'b0;
      flags_prev   <= '0;
    end else begin
      amplitude    <= next_amplitude;
      in_window    <= next_in_window;
      low_current  <= next_low_current;
      high_current <= next_high_current;
      flags_prev   <= flags;
    end
  end

  persist_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_zero_timer (
    .clock (clock),
    .rst   (rst),
    .cond  (low_current),
    .delay (zero_delay),
    .flag  (zero_flag)
  ); // [RULE_07]

  persist_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_over_timer (
    .clock (clock),
    .rst   (rst),
    .cond  (high_current),
    .delay (over_delay),
    .flag  (over_flag)
  ); // [RULE_10]

  always_comb begin
    flags = '0;
    flags[level_detect_pkg::FLAG_ANY_FREQUENCY] = in_window;
    flags[level_detect_pkg::FLAG_ZERO_CURRENT]  = zero_flag;
    flags[level_detect_pkg::FLAG_OVERCURRENT]   = over_flag;
    next_do_out    = route(do_select, flags); // [RULE_13]
    next_relay_out = route(relay_select, flags); // [RULE_13]
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      do_out    <= 1'b0;
      relay_out <= 1'b0;
    end else begin
      do_out    <= next_do_out;
      relay_out <= next_relay_out;
    end
  end

  // Checks
  sequence s_write(logic [15:0] a);
    wr_en && addr == a;
  endsequence

  property p_centre_range;
    @(posedge clock) disable iff (rst)
      s_write(level_detect_pkg::OFF_FREQ_CENTRE) |=>
        freq_centre == ($past(wr_data) <= $past(maximum_frequency_setting)
                        ? $past(wr_data) : $past(freq_centre));
  endproperty
  a_centre_range: assert property (p_centre_range) // [RULE_03]
    else $error("centre write not range checked");

  property p_amp_range;
    @(posedge clock) disable iff (rst)
      s_write(level_detect_pkg::OFF_FREQ_AMPLITUDE) ##0
        wr_data > level_detect_pkg::MAX_PERCENT_100 |=> $stable(freq_amplitude);
  endproperty
  a_amp_range: assert property (p_amp_range) // [RULE_04]
    else $error("amplitude accepted out of range");

  property p_amplitude;
    @(posedge clock) disable iff (rst)
      1'b1 |=> amplitude == 16'(({16'h0000, $past(maximum_frequency_setting)} *
                                 {16'h0000, $past(freq_amplitude)}) / 32'h0000_03E8);
  endproperty
  a_amplitude: assert property (p_amplitude) // [RULE_02]
    else $error("amplitude mismatch");

  property p_window;
    @(posedge clock) disable iff (rst)
      in_window |-> $past(operating_frequency) <= {16'h0000, $past(freq_centre)} + $past(amplitude)
                    && {16'h0000, $past(operating_frequency)} + $past(amplitude) >=
                       $past(freq_centre);
  endproperty
  a_window: assert property (p_window) // [RULE_01]
    else $error("frequency flag outside window");

  property p_low_current;
    @(posedge clock) disable iff (rst)
      low_current == ($past(output_current) <= $past(zero_level));
  endproperty
  a_low_current: assert property (p_low_current) // [RULE_06]
    else $error("low current compare wrong");

  property p_high_current;
    @(posedge clock) disable iff (rst)
      high_current == ($past(output_current) > $past(over_threshold));
  endproperty
  a_high_current: assert property (p_high_current) // [RULE_09]
    else $error("over limit compare wrong");

  property p_route_zero;
    @(posedge clock) disable iff (rst)
      do_select == level_detect_pkg::SEL_ZERO_CURRENT ##1 $stable(do_select) |->
        do_out == $past(zero_flag);
  endproperty
  a_route_zero: assert property (p_route_zero) // [RULE_08]
    else $error("output does not follow zero flag");

  property p_route_over;
    @(posedge clock) disable iff (rst)
      relay_select == level_detect_pkg::SEL_OVERCURRENT |=> relay_out == $past(over_flag);
  endproperty
  a_route_over: assert property (p_route_over) // [RULE_11]
    else $error("relay does not follow overcurrent flag");

  property p_route_freq;
    @(posedge clock) disable iff (rst)
      do_select == level_detect_pkg::SEL_ANY_FREQUENCY |=> do_out == $past(in_window);
  endproperty
  a_route_freq: assert property (p_route_freq) // [RULE_05]
    else $error("output does not follow frequency flag");

  property p_zero_release;
    @(posedge clock) disable iff (rst)
      !low_current |=> !zero_flag ##1 (!do_out || do_select != level_detect_pkg::SEL_ZERO_CURRENT
                                        || $past(do_select) != do_select);
  endproperty
  a_zero_release: assert property (p_zero_release) // [RULE_12]
    else $error("zero flag held after release");

  property p_irq;
    @(posedge clock) disable iff (rst) &(irq_status | ~$past(flags & ~flags_prev));
  endproperty
  a_irq: assert property (p_irq)
    else $error("rising flag did not set status");

endmodule

// ---- tb/output_load.sv ----
// External equipment on the output terminal and relay: counts activations.
// Assumes outputs are registered on clock and active high.
`timescale 1ns/100ps
module output_load (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic do_out,
  input  wire logic relay_out,
  output int        do_rises,
  output int        relay_rises
);
  logic do_last;
  logic relay_last;

  // Edge counts of each load
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      do_last     <= 1'b0;
      relay_last  <= 1'b0;
      do_rises    <= 0;
      relay_rises <= 0;
    end else begin
      do_last    <= do_out;
      relay_last <= relay_out;
      if (do_out && !do_last) begin
        do_rises <= do_rises + 1;
      end
      if (relay_out && !relay_last) begin
        relay_rises <= relay_rises + 1;
      end
    end
  end
endmodule

// ---- tb/drive_output_level_detectors_bench.sv ----
// Bench for the level detectors: registers, detectors, routing, interrupt.
// Assumes the package, timer and detector top are compiled first.
`timescale 1ns/100ps
module drive_output_level_detectors_bench;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wr_data = 16'h0000;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [15:0] rd_data;
  logic [15:0] freq = 16'h0000;
  logic [15:0] current = 16'h03E8;
  logic [15:0] max_freq = 16'h2710;
  logic        do_out;
  logic        relay_out;
  logic        irq;
  int          do_rises;
  int          relay_rises;
  int          n_mismatch = 0;
  int          compares = 0;
  logic [15:0] offs [8] = '{16'h0A01, 16'h0A02, 16'h0A19, 16'h0A1A,
                            16'h0A1D, 16'h0A1E, 16'h0A1F, 16'h0A20};
  logic [15:0] rsts [8] = '{16'h0002, 16'h0008, 16'h1388, 16'h0000,
                            16'h0032, 16'h000A, 16'h07D0, 16'h0001};
  logic [15:0] wfreq [5] = '{16'h0F9F, 16'h0FA0, 16'h1388, 16'h1770, 16'h1771};
  logic        win_in [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

  always #2.5 clock = ~clock;

  drive_output_level_detectors #(.TICK_CYCLES(4)) i_dut (
    .clock                     (clock),
    .rst                       (rst),
    .addr                      (addr),
    .wr_data                   (wr_data),
    .wr_en                     (wr_en),
    .rd_en                     (rd_en),
    .rd_data                   (rd_data),
    .operating_frequency       (freq),
    .output_current            (current),
    .maximum_frequency_setting (max_freq),
    .do_out                    (do_out),
    .relay_out                 (relay_out),
    .irq                       (irq)
  );

  output_load i_load (
    .clock       (clock),
    .rst         (rst),
    .do_out      (do_out),
    .relay_out   (relay_out),
    .do_rises    (do_rises),
    .relay_rises (relay_rises)
  );

  task automatic conclude;
    if (n_mismatch == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en   <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp, input string what);
    @(posedge clock);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    chk16(rd_data, exp, what);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic set_in(input logic [15:0] f, input logic [15:0] c);
    @(posedge clock);
    freq    <= f;
    current <= c;
  endtask

  // Pin 0 output terminal, 1 relay, 2 interrupt; looks after each of bound edges
  task automatic wait_pin(input int which, input logic v, input int bound);
    logic s;
    for (int i = 0; i < bound; i++) begin
      @(posedge clock);
      #1;
      s = (which == 0) ? do_out : (which == 1) ? relay_out : irq;
      if (s === v) return;
    end
    n_mismatch++;
    $display("unexpected at %0t: wait on pin %0d timed out", $time, which);
    conclude();
  endtask

  task automatic t_reset;
    for (int i = 0; i < 8; i++) begin
      rd_chk(offs[i], rsts[i], "reset value");
    end
    rd_chk(16'h0A00, 16'h0000, "unmapped read");
    cyc(1);
    chk16(rd_data, 16'h0000, "read data after its cycle");
    chk1(do_out, 1'b0, "idle output");
  endtask

  task automatic t_refuse;
    wr(16'h0A19, 16'h2711);
    rd_chk(16'h0A19, 16'h1388, "centre above maximum");
    wr(16'h0A19, 16'h2710);
    rd_chk(16'h0A19, 16'h2710, "centre at maximum");
    wr(16'h0A1A, 16'h03E9);
    rd_chk(16'h0A1A, 16'h0000, "amplitude above range");
    wr(16'h0A1D, 16'h0BB9);
    rd_chk(16'h0A1D, 16'h0032, "zero level above range");
    wr(16'h0A1E, 16'h0000);
    rd_chk(16'h0A1E, 16'h000A, "zero delay below range");
    wr(16'h0A01, 16'h0024);
    rd_chk(16'h0A01, 16'h0002, "selector above range");
  endtask

  task automatic t_window;
    wr(16'h0A01, 16'h0016);
    wr(16'h0A19, 16'h1388);
    wr(16'h0A1A, 16'h0064);
    for (int i = 0; i < 5; i++) begin
      set_in(wfreq[i], 16'h03E8);
      cyc(5);
      chk1(do_out, win_in[i], "frequency window");
      chk1(relay_out, 1'b0, "relay on other code");
    end
    wr(16'h0A02, 16'h0016);
    wr(16'h0A1A, 16'h0000);
    set_in(16'h1388, 16'h03E8);
    cyc(5);
    chk1(relay_out, 1'b1, "zero width at centre");
    set_in(16'h1389, 16'h03E8);
    cyc(5);
    chk1(relay_out, 1'b0, "zero width off centre");
    set_in(16'h0000, 16'h03E8);
  endtask

  task automatic t_zero;
    int base;
    base = do_rises;
    wr(16'h0A1E, 16'h0002);
    wr(16'h0A01, 16'h0007);
    wr(16'h0A02, 16'h001E);
    set_in(16'h0000, 16'h0032);
    cyc(8);
    chk1(do_out, 1'b0, "zero flag before delay");
    wait_pin(0, 1'b1, 20);
    chk1(relay_out, 1'b0, "relay on overcurrent code");
    set_in(16'h0000, 16'h0033);
    wait_pin(0, 1'b0, 3);
    set_in(16'h0000, 16'h0032);
    cyc(6);
    set_in(16'h0000, 16'h0033);
    cyc(2);
    set_in(16'h0000, 16'h0032);
    cyc(8);
    chk1(do_out, 1'b0, "zero timer restarted");
    wait_pin(0, 1'b1, 20);
    cyc(1);
    chk16(16'(do_rises - base), 16'h0002, "load activations");
    set_in(16'h0000, 16'h03E8);
  endtask

  task automatic t_over;
    int base;
    base = relay_rises;
    wr(16'h0A20, 16'h0000);
    set_in(16'h0000, 16'h07D0);
    cyc(20);
    chk1(relay_out, 1'b0, "current at threshold");
    set_in(16'h0000, 16'h07D1);
    wait_pin(1, 1'b1, 12);
    chk1(do_out, 1'b0, "terminal on zero code");
    set_in(16'h0000, 16'h03E8);
    wait_pin(1, 1'b0, 3);
    wr(16'h0A1F, 16'h05DC);
    set_in(16'h0000, 16'h0640);
    wait_pin(1, 1'b1, 12);
    set_in(16'h0000, 16'h03E8);
    cyc(1);
    chk16(16'(relay_rises - base), 16'h0002, "relay activations");
  endtask

  task automatic t_irq;
    rd_chk(level_detect_pkg::OFF_IRQ_STATUS, 16'h0007, "sticky status");
    chk1(irq, 1'b0, "all masked");
    wr(level_detect_pkg::OFF_IRQ_MASK, 16'h0002);
    wait_pin(2, 1'b1, 3);
    wr(level_detect_pkg::OFF_IRQ_STATUS, 16'h0002);
    wait_pin(2, 1'b0, 3);
    rd_chk(level_detect_pkg::OFF_IRQ_STATUS, 16'h0005, "status after clear");
    wr(level_detect_pkg::OFF_IRQ_MASK, 16'h0007);
    wait_pin(2, 1'b1, 3);
    wr(level_detect_pkg::OFF_IRQ_STATUS, 16'h0005);
    wait_pin(2, 1'b0, 3);
  endtask

  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_refuse();
    t_window();
    t_zero();
    t_over();
    t_irq();
    conclude();
  end
endmodule
